// >>> verilog/strap_latch_cfg.svh
`ifndef STRAP_LATCH_CFG_SVH
`define STRAP_LATCH_CFG_SVH

// Register byte offsets on the APB slave
`define OFS_STRAP_STATUS   12'h000
`define OFS_BOOT_STATUS    12'h004
`define OFS_OVERRIDE_CTRL  12'h008

// Field positions in the boot status word
`define BST_SDIO_1V8       0
`define BST_MODE_LO        1
`define BST_MODE_HI        2
`define BST_LOG_EN         3
`define BST_IN_RISING      4
`define BST_OUT_RISING     5
`define BST_RELEASED       8

// Width of the override control field (low bits of its word)
`define OVR_WIDTH          5

// Reset values
`define RST_OVERRIDE_CTRL  5'h00
`define RST_PRDATA         32'h0000_0000

// Weak pull pattern while reset holds, bit order as strap_bits_t:
// supply, boot select, boot aux, log/timing, sdio edge
`define PULL_UP_MASK       5'h0b
`define PULL_DOWN_MASK     5'h14

// Idle level of the UART transmit line while boot log is muted
`define UART_IDLE_LEVEL    1'b1

`endif

// >>> verilog/strap_latch_pkg.sv
package strap_latch_pkg;

  // Captured strap levels, one bit per pin
  typedef struct packed {
    logic supply_select;   // SDIO supply rail choice
    logic boot_select;     // Flash or download boot
    logic boot_aux;        // Qualifies download boot
    logic log_and_timing;  // Boot log, SDIO input edge
    logic sdio_edge;       // SDIO output edge
  } strap_bits_t;

  // Boot source decoded from the straps
  typedef enum logic [1:0] {
    BOOT_FLASH     = 2'h0,
    BOOT_DOWNLOAD  = 2'h1,
    BOOT_UNDEFINED = 2'h2
  } boot_mode_t;

  // Firmware overrides of the strap-derived settings
  typedef struct packed {
    logic out_rising;       // Forced output edge
    logic in_rising;        // Forced input edge
    logic timing_override;  // Use the two bits above
    logic volt_1v8;         // Forced supply choice
    logic volt_override;    // Use the bit above
  } override_ctrl_t;

  // Effective settings handed to the rest of the chip
  typedef struct packed {
    logic       sdio_1v8;    // 1: 1.8V rail, 0: higher default
    boot_mode_t boot_mode;   // Boot source
    logic       log_enable;  // UART0 boot log allowed
    logic       in_rising;   // SDIO slave samples on rising edge
    logic       out_rising;  // SDIO slave drives on rising edge
  } boot_settings_t;

  // Reset sequencing, Gray coded along the path
  typedef enum logic [1:0] {
    PH_SAMPLE  = 2'b00,
    PH_RELEASE = 2'b01,
    PH_RUN     = 2'b11
  } phase_t;

endpackage

// >>> verilog/strap_sync.sv
`timescale 1ns/1ps
`default_nettype none

module strap_sync
  import strap_latch_pkg::*;
#(
  parameter int WIDTH = 5  // Number of pins filtered
) (
  input  wire logic             mclk,
  input  wire logic [WIDTH-1:0] pin_async,
  output var  logic [WIDTH-1:0] pin_level
);

  // Three stages plus the agreed level
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } sync_state_t;

  sync_state_t st;       // Registered state
  sync_state_t next_st;  // Next state

  ////////////////////////////////////////////////////////////////////
  // Shift and filter; s1 feeds s2 only, to keep metastability away
  always_comb begin
    next_st    = st;
    next_st.s1 = pin_async;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < WIDTH; i++) begin
      // Accept a change once stages two and three agree
      if (st.s2[i] == st.s3[i]) begin
        next_st.level[i] = st.s3[i];
      end
    end
  end

  // No reset: the filter must keep tracking pins while reset holds
  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  assign pin_level = st.level;

endmodule

`default_nettype wire

// >>> verilog/strap_decode.sv
`timescale 1ns/1ps
`default_nettype none

module strap_decode
  import strap_latch_pkg::*;
(
  input  wire logic           clk_unused_free,
  input  strap_latch_pkg::strap_bits_t    straps,
  input  strap_latch_pkg::override_ctrl_t ovr,
  output strap_latch_pkg::boot_settings_t settings
);

  // Boot source from the two boot straps
  function automatic boot_mode_t boot_of(input strap_bits_t s);
    if (s.boot_select) begin
      boot_of = BOOT_FLASH;
    end else if (!s.boot_aux) begin
      boot_of = BOOT_DOWNLOAD;
    end else begin
      boot_of = BOOT_UNDEFINED;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Strap decode with firmware overrides on top
  always_comb begin
    settings.boot_mode  = boot_of(straps);
    settings.log_enable = straps.log_and_timing;
    // Supply rail: override wins once firmware sets it
    settings.sdio_1v8   = ovr.volt_override ? ovr.volt_1v8
                                            : straps.supply_select;
    // Edge pair: log strap picks input, edge strap picks output
    settings.in_rising  = ovr.timing_override ? ovr.in_rising
                                              : straps.log_and_timing;
    settings.out_rising = ovr.timing_override ? ovr.out_rising
                                              : straps.sdio_edge;
  end

endmodule

`default_nettype wire

// >>> verilog/strap_pin_boot_latch.sv
// How it works
// - Sample all five straps during any reset
// - Captured straps hold until the next reset
// - Software reads captured straps in status register
// - Weak pulls enabled on straps during reset
// - Pins released to normal use after reset
// - Supply strap 1 selects 1.8V rail
// - Boot select/aux decode flash or download
// - Log strap mutes or enables UART0 log
// - Log/edge strap pair sets SDIO edges
// - Firmware bits override supply and SDIO timing
`include "strap_latch_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module strap_pin_boot_latch
  import strap_latch_pkg::*;
(
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  // Strap pins, asynchronous to mclk
  input  wire logic                        strap_supply_select,
  input  wire logic                        strap_boot_select,
  input  wire logic                        strap_boot_aux,
  input  wire logic                        strap_log_and_timing,
  input  wire logic                        strap_sdio_edge,
  // Weak pull controls toward the pads
  output strap_latch_pkg::strap_bits_t     strap_pull_up_en,
  output strap_latch_pkg::strap_bits_t     strap_pull_down_en,
  output var  logic                        straps_released,
  // Decoded settings for the rest of the chip
  output strap_latch_pkg::boot_settings_t  boot_settings,
  // Boot log path toward the UART0 pad
  input  wire logic                        boot_log_data,
  output var  logic                        uart0_transmit_line,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output var  logic [31:0]                 prdata,
  output var  logic                        pready,
  output var  logic                        pslverr
);

  ////////////////////////////////////////////////////////////////////
  // State of the whole block in one register

  typedef struct packed {
    phase_t         phase;       // Reset sequencing
    strap_bits_t    strap;       // Captured strap levels
    override_ctrl_t ovr;         // Firmware overrides
    strap_bits_t    pull_up;     // Pull-up enables
    strap_bits_t    pull_down;   // Pull-down enables
    logic           released;    // Pins in normal use
    boot_settings_t settings;    // Registered decode
    logic           uart_line;   // Gated UART0 level
    logic [31:0]    rdata;       // APB read data
    logic           ready;       // APB ready
    logic           slverr;      // APB error
  } latch_state_t;

  latch_state_t   st;            // Registered state
  latch_state_t   next_st;       // Next state

  strap_bits_t    pins_raw;      // Pins packed, unsynchronised
  strap_bits_t    pins_level;    // Filtered pin levels
  boot_settings_t decoded;       // Live decode of st.strap

  ////////////////////////////////////////////////////////////////////
  // Pin filtering and decode

  // Pack the pins in the documented strap order
  assign pins_raw = '{supply_select:  strap_supply_select,
                      boot_select:    strap_boot_select,
                      boot_aux:       strap_boot_aux,
                      log_and_timing: strap_log_and_timing,
                      sdio_edge:      strap_sdio_edge};

  // Three-stage filter; pins are outside the mclk domain
  strap_sync #(
    .WIDTH     ($bits(strap_bits_t))
  ) u_sync (
    .mclk      (mclk),
    .pin_async (pins_raw),
    .pin_level (pins_level)
  );

  // Settings from the frozen straps plus overrides
  strap_decode u_decode (
    .clk_unused_free (mclk),
    .straps          (st.strap),
    .ovr             (st.ovr),
    .settings        (decoded)
  );

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // True when an APB address hits a given register offset
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // Boot status word from effective settings and release state
  function automatic logic [31:0] boot_word(input boot_settings_t s,
                                            input logic rel);
    logic [31:0] w;
    w                     = 32'h0000_0000;
    w[`BST_SDIO_1V8]      = s.sdio_1v8;
    w[`BST_MODE_HI:`BST_MODE_LO] = s.boot_mode;
    w[`BST_LOG_EN]        = s.log_enable;
    w[`BST_IN_RISING]     = s.in_rising;
    w[`BST_OUT_RISING]    = s.out_rising;
    w[`BST_RELEASED]      = rel;
    boot_word             = w;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    next_st = st;

    //----------------------------------------------------------------
    // Reset: latch follows the pins, pulls on, bus quiet
    if (!rstn) begin
      next_st.phase     = PH_SAMPLE;
      // Transparent while reset holds; the filter already
      // suppresses single-sample glitches on the pads
      next_st.strap     = pins_level;
      // Pulls resolve floating pins to their defaults
      next_st.pull_up   = strap_bits_t'(`PULL_UP_MASK);
      next_st.pull_down = strap_bits_t'(`PULL_DOWN_MASK);
      next_st.released  = 1'b0;
      next_st.ovr       = override_ctrl_t'(`RST_OVERRIDE_CTRL);
      next_st.settings  = decoded;
      // Keep the UART pad idle until boot decides
      next_st.uart_line = `UART_IDLE_LEVEL;
      next_st.rdata     = `RST_PRDATA;
      next_st.ready     = 1'b0;
      next_st.slverr    = 1'b0;
    end else begin

      //--------------------------------------------------------------
      // Release sequence after reset
      unique case (st.phase)
        // First edge with reset high freezes the latch;
        // pulls stay on one more cycle so the pins cannot
        // move while the last sample settles
        PH_SAMPLE: begin
          next_st.phase = PH_RELEASE;
        end
        // Now drop the pulls and hand the pins back
        PH_RELEASE: begin
          next_st.phase     = PH_RUN;
          next_st.pull_up   = '0;
          next_st.pull_down = '0;
          next_st.released  = 1'b1;
        end
        // Normal running: nothing more to sequence
        PH_RUN: begin
          next_st.phase = PH_RUN;
        end
        // Illegal Gray code: restart the release safely
        default: begin
          next_st.phase = PH_RELEASE;
        end
      endcase

      // Straps are never written outside reset, so pin
      // activity after release cannot disturb them
      next_st.strap = st.strap;

      //--------------------------------------------------------------
      // Registered decode toward the rest of the chip
      next_st.settings = decoded;

      // Log strap gates the boot log onto UART0
      if (decoded.log_enable) begin
        next_st.uart_line = boot_log_data;
      end else begin
        // Muted: hold the line at its idle level
        next_st.uart_line = `UART_IDLE_LEVEL;
      end

      //--------------------------------------------------------------
      // APB slave: answer prepared in setup, ready in access
      next_st.ready  = 1'b0;
      next_st.slverr = 1'b0;
      if (psel && !penable) begin
        // Setup phase: decode and present data next cycle
        next_st.ready = 1'b1;
        if (hit(paddr, `OFS_STRAP_STATUS)) begin
          // Captured bits, read-only
          next_st.rdata = {27'h000_0000, st.strap};
          next_st.slverr = pwrite;
        end else if (hit(paddr, `OFS_BOOT_STATUS)) begin
          // Effective settings, read-only
          next_st.rdata  = boot_word(decoded, st.released);
          next_st.slverr = pwrite;
        end else if (hit(paddr, `OFS_OVERRIDE_CTRL)) begin
          // Overrides read back as written
          next_st.rdata = {27'h000_0000, st.ovr};
        end else begin
          // Unmapped: zero data and an error
          next_st.rdata  = 32'h0000_0000;
          next_st.slverr = 1'b1;
        end
      end

      // Access phase completes while ready is high
      if (psel && penable && st.ready && pwrite && !st.slverr) begin
        if (hit(paddr, `OFS_OVERRIDE_CTRL)) begin
          // Firmware may override supply and SDIO timing
          next_st.ovr = override_ctrl_t'(
                          pwdata[`OVR_WIDTH-1:0]);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register, reset handled synchronously in the comb block

  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  // Pads see fixed pull pattern while reset holds
  assign strap_pull_up_en    = st.pull_up;
  assign strap_pull_down_en  = st.pull_down;
  // High once pins are back in normal use
  assign straps_released     = st.released;
  // Decoded boot settings, one cycle behind the latch
  assign boot_settings       = st.settings;
  // Boot log, or idle when the log strap mutes it
  assign uart0_transmit_line = st.uart_line;
  // Bus answer
  assign prdata              = st.rdata;
  assign pready              = st.ready;
  assign pslverr             = st.slverr;

endmodule

`default_nettype wire

// >>> verification/strap_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

// Pads outside the latch: pulls, host pins or a floating wire
module strap_pin_model
  import strap_latch_pkg::*;
(
  input  wire logic                         mclk,
  input  var  strap_latch_pkg::strap_bits_t pull_up_en,
  input  var  strap_latch_pkg::strap_bits_t pull_down_en,
  input  wire logic                         host_drive_en,
  input  var  strap_latch_pkg::strap_bits_t host_level,
  output var  strap_latch_pkg::strap_bits_t pin_level
);
  strap_bits_t float_pat;  // Undriven level, flips every cycle

  ////////////////////////////////////////////////////////////////////////////
  // A floating pad must not look like a held value
  initial float_pat = 5'h15;
  always @(posedge mclk) float_pat <= ~float_pat;

  // Host beats weak pulls; pulls beat a floating pad
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (host_drive_en) begin
        pin_level[i] = host_level[i];
      end else if (pull_up_en[i]) begin
        pin_level[i] = 1'b1;
      end else if (pull_down_en[i]) begin
        pin_level[i] = 1'b0;
      end else begin
        pin_level[i] = float_pat[i];
      end
    end
  end
endmodule

`default_nettype wire

// >>> verification/strap_latch_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module strap_latch_monitor
  import strap_latch_pkg::*;
(
  input  wire logic                            mclk,
  input  wire logic                            rstn,
  input  var  strap_latch_pkg::strap_bits_t    strap_pull_up_en,
  input  var  strap_latch_pkg::strap_bits_t    strap_pull_down_en,
  input  wire logic                            straps_released,
  input  var  strap_latch_pkg::boot_settings_t boot_settings,
  input  wire logic                            boot_log_data,
  input  wire logic                            uart0_transmit_line,
  input  wire logic                            pready,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [11:0]                     paddr,
  input  wire logic [31:0]                     pwdata,
  input  wire logic [31:0]                     prdata,
  input  wire logic                            pslverr
);
  // One domain, so one clock and one reset for all
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////////
  property p_pull_release;
    $rose(rstn) |-> (strap_pull_up_en == 5'h0b && !straps_released)
      ##1 (strap_pull_down_en == 5'h14 && !straps_released)
      ##1 (strap_pull_up_en == 5'h00 && strap_pull_down_en == 5'h00
           && straps_released);
  endproperty
  a_pull_release: assert property (p_pull_release)
    else $error("pull release sequence wrong");
  property p_hold;
    straps_released && $past(straps_released) |->
      $stable(boot_settings.log_enable) && $stable(boot_settings.boot_mode);
  endproperty
  a_hold: assert property (p_hold)
    else $error("strap settings moved after boot");
  property p_log_on;
    straps_released && boot_settings.log_enable |=>
      uart0_transmit_line == $past(boot_log_data);
  endproperty
  a_log_on: assert property (p_log_on)
    else $error("boot log not passed to uart");
  property p_log_off;
    straps_released && !boot_settings.log_enable |=> uart0_transmit_line;
  endproperty
  a_log_off: assert property (p_log_off)
    else $error("uart not silent");
  property p_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("pready timing wrong");
  property p_ro;
    pready && pwrite && paddr != 12'h008 |-> pslverr;
  endproperty
  a_ro: assert property (p_ro)
    else $error("write to read-only accepted");
  property p_unmapped;
    pready && paddr > 12'h008 |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  property p_volt_ovr;
    pready && pwrite && paddr == 12'h008 && pwdata[0] |->
      ##2 boot_settings.sdio_1v8 == $past(pwdata[1], 2);
  endproperty
  a_volt_ovr: assert property (p_volt_ovr)
    else $error("supply override ignored");
  property p_time_ovr;
    pready && pwrite && paddr == 12'h008 && pwdata[2] |->
      ##2 {boot_settings.in_rising, boot_settings.out_rising}
        == $past(pwdata[4:3], 2);
  endproperty
  a_time_ovr: assert property (p_time_ovr)
    else $error("timing override ignored");
endmodule

bind strap_pin_boot_latch strap_latch_monitor strap_latch_monitor_inst (
  .mclk(mclk), .rstn(rstn), .strap_pull_up_en(strap_pull_up_en),
  .strap_pull_down_en(strap_pull_down_en),
  .straps_released(straps_released), .boot_settings(boot_settings),
  .boot_log_data(boot_log_data), .uart0_transmit_line(uart0_transmit_line),
  .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr));

`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import strap_latch_pkg::*;
  logic           mclk, rstn, psel, penable, pwrite, boot_log_data;
  logic [11:0]    paddr;
  logic [31:0]    pwdata, prdata;
  logic           pready, pslverr, straps_released, uart_line, host_drive_en;
  strap_bits_t    pull_up, pull_down, pins, host_level;
  boot_settings_t settings;
  int             bad_count, n_checks;
  strap_bits_t    vecs [8] = '{5'h0b, 5'h00, 5'h15, 5'h02, 5'h11, 5'h08,
                               5'h0f, 5'h1b};  // First entry left floating

  strap_pin_boot_latch strap_pin_boot_latch_inst (
    .mclk(mclk), .rstn(rstn), .strap_supply_select(pins.supply_select),
    .strap_boot_select(pins.boot_select), .strap_boot_aux(pins.boot_aux),
    .strap_log_and_timing(pins.log_and_timing),
    .strap_sdio_edge(pins.sdio_edge), .strap_pull_up_en(pull_up),
    .strap_pull_down_en(pull_down), .straps_released(straps_released),
    .boot_settings(settings), .boot_log_data(boot_log_data),
    .uart0_transmit_line(uart_line), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  strap_pin_model strap_pin_model_inst (
    .mclk(mclk), .pull_up_en(pull_up), .pull_down_en(pull_down),
    .host_drive_en(host_drive_en), .host_level(host_level),
    .pin_level(pins));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 100 ns period; log data toggles so the uart path is visible
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) boot_log_data <= ~boot_log_data;

  task automatic tally_and_finish();
    if (bad_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready with a bound
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, input logic [31:0] exp,
                     input logic exp_err);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (!wr) chk(prdata, exp);
    chk({31'h0000_0000, pslverr}, {31'h0000_0000, exp_err});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Expected decode of a strap word
  function automatic logic [1:0] mode_of(strap_bits_t s);
    if (s.boot_select) return BOOT_FLASH;
    return s.boot_aux ? BOOT_UNDEFINED : BOOT_DOWNLOAD;
  endfunction

  // Reset with the host holding levels, then move the pins away
  task automatic boot_with(input logic drv, input strap_bits_t v);
    @(posedge mclk);
    rstn <= 1'b0;
    host_drive_en <= drv;
    host_level <= v;
    repeat (6) @(posedge mclk);
    chk({27'h000_0000, pull_up}, 32'h0000_000b);
    chk({27'h000_0000, pull_down}, 32'h0000_0014);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    host_level <= ~v;
    chk({27'h000_0000, pull_up, straps_released}, 32'h0000_0001);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    strap_bits_t v;
    logic [31:0] st;
    rstn = 1'b0;
    {psel, penable, pwrite, boot_log_data, host_drive_en} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    host_level = 5'h00;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      v = vecs[i];
      boot_with(i != 0, v);
      st = {23'h00_0000, 1'b1, 2'h0, v.sdio_edge, v.log_and_timing,
            v.log_and_timing, mode_of(v), v.supply_select};
      apb(1'b0, 12'h000, 32'h0000_0000, {27'h000_0000, v}, 1'b0);
      apb(1'b0, 12'h004, 32'h0000_0000, st, 1'b0);
      chk({26'h000_0000, settings}, {26'h000_0000, st[0], st[2:1], st[3],
          st[4], st[5]});
    end
    // Pins float after release; latch must not follow
    host_drive_en <= 1'b0;
    repeat (5) @(posedge mclk);
    apb(1'b0, 12'h000, 32'h0000_0000, 32'h0000_001b, 1'b0);
    // Firmware forces 3.3V and falling edges, then gives control back
    apb(1'b1, 12'h008, 32'h0000_0005, 32'h0000_0000, 1'b0);
    repeat (3) @(posedge mclk);
    chk({26'h000_0000, settings}, 32'h0000_0004);
    apb(1'b0, 12'h008, 32'h0000_0000, 32'h0000_0005, 1'b0);
    apb(1'b1, 12'h008, 32'h0000_0000, 32'h0000_0000, 1'b0);
    repeat (3) @(posedge mclk);
    chk({26'h000_0000, settings}, 32'h0000_0027);
    // Read-only and unmapped places refuse
    apb(1'b1, 12'h000, 32'h0000_001f, 32'h0000_0000, 1'b1);
    apb(1'b1, 12'h004, 32'h0000_00ff, 32'h0000_0000, 1'b1);
    apb(1'b0, 12'h010, 32'h0000_0000, 32'h0000_0000, 1'b1);
    apb(1'b0, 12'h000, 32'h0000_0000, 32'h0000_001b, 1'b0);
    // Tenth reset clears overrides and samples again
    apb(1'b1, 12'h008, 32'h0000_001f, 32'h0000_0000, 1'b0);
    boot_with(1'b1, 5'h15);
    apb(1'b0, 12'h008, 32'h0000_0000, 32'h0000_0000, 1'b0);
    apb(1'b0, 12'h000, 32'h0000_0000, 32'h0000_0015, 1'b0);
    tally_and_finish();
  end

  // Watchdog, well past the expected few hundred cycles
  initial begin
    repeat (5000) @(posedge mclk);
    bad_count++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
